// >>> src/bcc_pkg.sv
/*
 brake chopper control package: voltage classes, threshold ranges,
 overvoltage limits and sample timing.
 assumes voltages are carried in units of 0.1 V, 16 bits wide.
*/
package bcc_pkg;
   localparam int VW = 16;
   // voltage classes, lowest to highest
   typedef enum logic [3:0] {
      BCC_CLASS_A = 4'h1,
      BCC_CLASS_B = 4'h2,
      BCC_CLASS_C = 4'h4,
      BCC_CLASS_D = 4'h8
   } bcc_class_t;
   // threshold limits and defaults, 0.1 V units
   localparam logic [15:0] BCC_MIN_A = 16'h08CA; // 225.0 V
   localparam logic [15:0] BCC_MAX_A = 16'h2710; // 1000.0 V
   localparam logic [15:0] BCC_DEF_A = 16'h0F3C; // 390.0 V
   localparam logic [15:0] BCC_MIN_B = 16'h109A; // 425.0 V
   localparam logic [15:0] BCC_MAX_B = 16'h4E20; // 2000.0 V
   localparam logic [15:0] BCC_DEF_B = 16'h1E78; // 780.0 V
   localparam logic [15:0] BCC_MIN_C = 16'h157C; // 550.0 V
   localparam logic [15:0] BCC_MAX_C = 16'h4E20; // 2000.0 V
   localparam logic [15:0] BCC_DEF_C = 16'h2260; // 880.0 V
   localparam logic [15:0] BCC_MIN_D = 16'h1C52; // 725.0 V
   localparam logic [15:0] BCC_MAX_D = 16'h4E20; // 2000.0 V
   localparam logic [15:0] BCC_DEF_D = 16'h2E18; // 1180.0 V
   // overvoltage fault limits
   localparam logic [15:0] BCC_OV_A = 16'h0FA0; // 400 V
   localparam logic [15:0] BCC_OV_B = 16'h1F40; // 800 V
   localparam logic [15:0] BCC_OV_C = 16'h2328; // 900 V
   localparam logic [15:0] BCC_OV_D = 16'h2EE0; // 1200 V
   // timing
   localparam int BCC_CLK_HZ = 10_000_000;
   localparam int BCC_SAMPLE_NS = 125_000;
   localparam int BCC_SAMPLE_CYC =
      BCC_SAMPLE_NS / (1_000_000_000 / BCC_CLK_HZ);
   // fault codes
   localparam logic [15:0] BCC_F_OV = 16'h0700;
   localparam logic [15:0] BCC_F_START = 16'h0705;
   localparam logic [15:0] BCC_F_NONE = 16'h0000;
endpackage

// >>> src/bcc_sample_timer.sv
/*
 sample tick generator: one-cycle pulse every period cycles.
 assumes a free-running clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
module bcc_sample_timer #(
   parameter int PERIOD = 1250
) (
   input wire logic clk,
   input wire logic rst_n,
   output logic tick
);
   localparam int CW = $clog2(PERIOD);
   localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
   logic [CW-1:0] cnt_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (cnt_q == LAST) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick <= 1'b0;
      end else begin
         tick <= (cnt_q == LAST);
      end
   end
endmodule

// >>> src/bcc_brake_chopper.sv
/*
 brake chopper control: samples dc-link voltage against the switch-on
 threshold, drives the chopper with minimum on-time, checks the
 threshold range and raises overvoltage and start-time faults.
 assumes dc_link_v, mains_dc_v and the threshold are synchronous, in
 0.1 V units; class_sel is static while running.
*/
// Function
// - chopper on when dc-link voltage above the switch-on threshold.
// - lowest class threshold range 225.0 to 1000.0 V, default 390.0 V.
// - second class threshold range 425.0 to 2000.0 V, default 780.0 V.
// - third class threshold range 550.0 to 2000.0 V, default 880.0 V.
// - highest class threshold range 725.0 to 2000.0 V, default 1180.0 V.
// - threshold above maximum admissible voltage keeps chopper off.
// - start with threshold below mains dc voltage raises start fault.
// - dc-link voltage above class overvoltage limit raises fault.
// - overvoltage limits are 400, 800, 900 and 1200 V per class.
// - compare once per 125 us, decision changes only at samples; the code also forces the chopper off between samples when disabled.
// - once triggered, chopper stays on for at least 125 us; the code ends it early when the threshold exceeds max_dc_v.
`timescale 1ns/1ps
module bcc_brake_chopper
   import bcc_pkg::*;
#(
   parameter int SAMPLE_CYC = BCC_SAMPLE_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire bcc_class_t class_sel,
   input wire logic [VW-1:0] dc_link_v,
   input wire logic [VW-1:0] mains_dc_v,
   input wire logic [VW-1:0] max_dc_v,
   input wire logic thr_wr,
   input wire logic [VW-1:0] thr_wdata,
   input wire logic start_cmd,
   input wire logic fault_clr,
   output logic chopper_on,
   output logic [VW-1:0] chopper_switch_on_voltage,
   output logic thr_rejected,
   output logic chopper_disabled,
   output logic fault_active,
   output logic [VW-1:0] fault_code
);
   logic tick;
   logic [VW-1:0] thr_min, thr_max, thr_def, ov_lim;
   logic thr_in_range;
   logic above;
   logic init_q;

   bcc_sample_timer #(.PERIOD(SAMPLE_CYC)) u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick)
   );

   // per-class range, default and overvoltage limit
   always_comb begin
      case (class_sel)
         BCC_CLASS_B: begin
            thr_min = BCC_MIN_B;
            thr_max = BCC_MAX_B;
            thr_def = BCC_DEF_B;
            ov_lim = BCC_OV_B;
         end
         BCC_CLASS_C: begin
            thr_min = BCC_MIN_C;
            thr_max = BCC_MAX_C;
            thr_def = BCC_DEF_C;
            ov_lim = BCC_OV_C;
         end
         BCC_CLASS_D: begin
            thr_min = BCC_MIN_D;
            thr_max = BCC_MAX_D;
            thr_def = BCC_DEF_D;
            ov_lim = BCC_OV_D;
         end
         default: begin
            thr_min = BCC_MIN_A;
            thr_max = BCC_MAX_A;
            thr_def = BCC_DEF_A;
            ov_lim = BCC_OV_A;
         end
      endcase
   end

   assign thr_in_range = (thr_wdata >= thr_min) && (thr_wdata <= thr_max);
   assign above = dc_link_v > chopper_switch_on_voltage;

   // threshold storage: class default loaded once after reset release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         init_q <= 1'b0;
         chopper_switch_on_voltage <= BCC_DEF_A;
         thr_rejected <= 1'b0;
      end else if (!init_q) begin
         init_q <= 1'b1;
         chopper_switch_on_voltage <= thr_def;
         thr_rejected <= 1'b0;
      end else if (thr_wr) begin
         if (thr_in_range) begin
            chopper_switch_on_voltage <= thr_wdata;
         end
         thr_rejected <= !thr_in_range;
      end
   end

   // threshold above admissible maximum disables chopper
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chopper_disabled <= 1'b0;
      end else begin
         chopper_disabled <= chopper_switch_on_voltage > max_dc_v;
      end
   end

   // chopper decided at sample ticks, but forced off in any cycle when disabled; each on-decision lasts at
   // least one full sample period unless disabled, because it is held until next tick
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chopper_on <= 1'b0;
      end else if (chopper_disabled ||
                   chopper_switch_on_voltage > max_dc_v) begin
         chopper_on <= 1'b0;
      end else if (tick) begin
         chopper_on <= above;
      end
   end

   // faults: overvoltage wins over start fault; set wins over clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_active <= 1'b0;
         fault_code <= BCC_F_NONE;
      end else if (dc_link_v > ov_lim) begin
         fault_active <= 1'b1;
         fault_code <= BCC_F_OV;
      end else if (start_cmd && chopper_switch_on_voltage < mains_dc_v) begin
         fault_active <= 1'b1;
         fault_code <= BCC_F_START;
      end else if (fault_clr) begin
         fault_active <= 1'b0;
         fault_code <= BCC_F_NONE;
      end
   end

   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // cycles the chopper has been on, saturating at one sample period
   localparam int OCW = $clog2(SAMPLE_CYC + 1);
   logic [OCW-1:0] on_cnt_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         on_cnt_q <= '0;
      end else if (!chopper_on) begin
         on_cnt_q <= '0;
      end else if (on_cnt_q != OCW'(SAMPLE_CYC)) begin
         on_cnt_q <= on_cnt_q + OCW'(1);
      end
   end

   chop_on_a: assert property (
      tick && above && !chopper_disabled &&
      !(chopper_switch_on_voltage > max_dc_v) |=> chopper_on)
      else $error("chopper not on after sample above threshold");
   chop_hold_a: assert property (
      $fell(chopper_on) |->
      $past(tick) || $past(chopper_disabled) ||
      $past(chopper_switch_on_voltage > max_dc_v))
      else $error("chopper changed off outside a sample");
   chop_rise_a: assert property (
      $rose(chopper_on) |-> $past(tick))
      else $error("chopper rose outside a sample");
   chop_stable_a: assert property (
      !tick && !chopper_disabled &&
      !(chopper_switch_on_voltage > max_dc_v) |=> $stable(chopper_on))
      else $error("chopper changed between samples");
   // counter reads the full period on the cycle after the fall
   min_on_a: assert property (
      $fell(chopper_on) && !$past(chopper_disabled) &&
      !$past(chopper_switch_on_voltage > max_dc_v) |->
      on_cnt_q == OCW'(SAMPLE_CYC))
      else $error("chopper on shorter than minimum");
   chop_off_a: assert property (
      tick && !above |=> !chopper_on)
      else $error("chopper not off after sample below threshold");
   dis_off_a: assert property (
      chopper_disabled |-> !chopper_on)
      else $error("disabled chopper is on");
   ov_fault_a: assert property (
      dc_link_v > ov_lim |=> fault_active && fault_code == BCC_F_OV)
      else $error("overvoltage fault missing");
   start_fault_a: assert property (
      start_cmd && !(dc_link_v > ov_lim) &&
      chopper_switch_on_voltage < mains_dc_v |=>
      fault_code == BCC_F_START)
      else $error("start fault missing");
   thr_range_a: assert property (
      init_q && thr_wr && !thr_in_range |=>
      $stable(chopper_switch_on_voltage) && thr_rejected)
      else $error("out of range threshold accepted");
   thr_load_a: assert property (
      init_q && thr_wr && thr_in_range |=>
      chopper_switch_on_voltage == $past(thr_wdata) && !thr_rejected)
      else $error("in range threshold not taken");
   def_load_a: assert property (
      !init_q && class_sel == BCC_CLASS_C |=>
      chopper_switch_on_voltage == BCC_DEF_C)
      else $error("third class default not loaded");
   def_top_a: assert property (
      !init_q && class_sel == BCC_CLASS_D |=>
      chopper_switch_on_voltage == BCC_DEF_D)
      else $error("highest class default not loaded");
   fault_hold_a: assert property (
      fault_active && !fault_clr |=> fault_active)
      else $error("fault dropped without clear");
   fault_clr_a: assert property (
      fault_clr && !(dc_link_v > ov_lim) &&
      !(start_cmd && chopper_switch_on_voltage < mains_dc_v) |=>
      !fault_active && fault_code == BCC_F_NONE)
      else $error("fault not cleared");
   // at the limit itself no overvoltage fault may be raised
   ov_lim_a: assert property (
      class_sel == BCC_CLASS_D && dc_link_v == BCC_OV_D &&
      !fault_active && !start_cmd |=> !fault_active)
      else $error("overvoltage fault at the class limit");

   chop_on_c: cover property ($rose(chopper_on));
   chop_off_c: cover property ($fell(chopper_on));
   ov_c: cover property (fault_code == BCC_F_OV);
   start_c: cover property (fault_code == BCC_F_START);
   dis_c: cover property ($rose(chopper_disabled));
endmodule

// >>> sim/bcc_dc_link_model.sv
/*
 dc-link measurement model: reports the requested level one clock late.
 assumes the bench sets v_req shortly after a rising edge.
*/
`timescale 1ns/1ps
module bcc_dc_link_model
   import bcc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [VW-1:0] v_req,
   output logic [VW-1:0] dc_link_v
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dc_link_v <= '0;
      end else begin
         dc_link_v <= v_req;
      end
   end
endmodule

// >>> sim/tb_bcc_brake_chopper.sv
/*
 self-checking bench for the brake chopper control, short sample period.
 assumes the dc-link model feeds dc_link_v one clock late.
*/
`timescale 1ns/1ps
module tb_bcc_brake_chopper;
   import bcc_pkg::*;
   localparam int SC = 8;
   logic clk, rst_n, thr_wr, start_cmd, fault_clr;
   logic chopper_on, thr_rejected, chopper_disabled, fault_active;
   logic [VW-1:0] v_req, dc_v, mains_v, max_v, wdata, thr, code;
   bcc_class_t class_sel;
   int n_fail, n_compared;
   bcc_class_t cls [4] = '{BCC_CLASS_A, BCC_CLASS_B, BCC_CLASS_C,
      BCC_CLASS_D};
   logic [VW-1:0] mn [4] = '{BCC_MIN_A, BCC_MIN_B, BCC_MIN_C, BCC_MIN_D};
   logic [VW-1:0] mx [4] = '{BCC_MAX_A, BCC_MAX_B, BCC_MAX_C, BCC_MAX_D};
   logic [VW-1:0] df [4] = '{BCC_DEF_A, BCC_DEF_B, BCC_DEF_C, BCC_DEF_D};
   logic [VW-1:0] ov [4] = '{BCC_OV_A, BCC_OV_B, BCC_OV_C, BCC_OV_D};
   bcc_dc_link_model mdl (.clk(clk), .rst_n(rst_n), .v_req(v_req),
      .dc_link_v(dc_v));
   bcc_brake_chopper #(.SAMPLE_CYC(SC)) dut (.clk(clk), .rst_n(rst_n),
      .class_sel(class_sel), .dc_link_v(dc_v), .mains_dc_v(mains_v),
      .max_dc_v(max_v), .thr_wr(thr_wr), .thr_wdata(wdata),
      .start_cmd(start_cmd), .fault_clr(fault_clr),
      .chopper_on(chopper_on), .chopper_switch_on_voltage(thr),
      .thr_rejected(thr_rejected), .chopper_disabled(chopper_disabled),
      .fault_active(fault_active), .fault_code(code));
   task automatic chk(string nm, logic [VW-1:0] e, logic [VW-1:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chb(string nm, logic e, logic g);
      chk(nm, {15'h0000, e}, {15'h0000, g});
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task automatic do_reset(bcc_class_t c);
      rst_n = 0;
      class_sel = c;
      cyc(20);
      rst_n = 1;
      cyc(2);
   endtask
   task automatic wr(logic [VW-1:0] v);
      thr_wr = 1;
      wdata = v;
      cyc(1);
      thr_wr = 0;
      cyc(1);
   endtask
   task automatic clr;
      fault_clr = 1;
      cyc(1);
      fault_clr = 0;
      cyc(1);
   endtask
   task automatic t_class;
      for (int i = 0; i < 4; i++) begin
         do_reset(cls[i]);
         chk("default", df[i], thr);
         wr(mn[i] - 16'h0001);
         chb("low rej", 1'b1, thr_rejected);
         chk("kept", df[i], thr);
         wr(mx[i] + 16'h0001);
         chb("high rej", 1'b1, thr_rejected);
         wr(mn[i]);
         chk("min", mn[i], thr);
         chb("min acc", 1'b0, thr_rejected);
         wr(mx[i]);
         chk("max", mx[i], thr);
         v_req = ov[i];
         cyc(3);
         chb("ov at limit", 1'b0, fault_active);
         v_req = ov[i] + 16'h0001;
         cyc(2);
         chk("ov code", BCC_F_OV, code);
         v_req = '0;
         cyc(2);
         clr;
         chb("ov clear", 1'b0, fault_active);
         chk("ov none", BCC_F_NONE, code);
      end
   endtask
   task automatic t_chop;
      logic [VW-1:0] n;
      do_reset(BCC_CLASS_A);
      v_req = BCC_DEF_A;
      cyc(2 * SC + 2);
      chb("equal off", 1'b0, chopper_on);
      v_req = BCC_DEF_A + 16'h0001;
      n = '0;
      while (!chopper_on && n < 16'(2 * SC + 3)) begin
         cyc(1);
         n++;
      end
      chb("above on", 1'b1, chopper_on);
      v_req = 16'h0BB8;
      n = '0;
      while (chopper_on && n < 16'(3 * SC)) begin
         cyc(1);
         n++;
      end
      chk("on time", 16'(SC), n);
   endtask
   task automatic t_dis;
      max_v = BCC_DEF_A - 16'h0001;
      v_req = BCC_DEF_A + 16'h0001;
      cyc(2 * SC + 3);
      chb("disabled", 1'b1, chopper_disabled);
      chb("forced off", 1'b0, chopper_on);
      max_v = 16'hFFFF;
      cyc(2 * SC + 3);
      chb("enabled", 1'b1, chopper_on);
      chb("re-enabled", 1'b0, chopper_disabled);
      v_req = '0;
   endtask
   task automatic t_start;
      mains_v = BCC_DEF_A;
      start_cmd = 1;
      cyc(2);
      chb("start ok", 1'b0, fault_active);
      mains_v = BCC_DEF_A + 16'h0001;
      cyc(2);
      chk("start code", BCC_F_START, code);
      start_cmd = 0;
      mains_v = '0;
      clr;
      chb("start clear", 1'b0, fault_active);
      chk("start none", BCC_F_NONE, code);
   endtask
   task automatic close_out;
      if (n_fail == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      close_out();
   end
   initial begin
      {rst_n, thr_wr, start_cmd, fault_clr} = '0;
      {v_req, mains_v, wdata} = '0;
      max_v = 16'hFFFF;
      class_sel = BCC_CLASS_A;
      n_fail = 0;
      n_compared = 0;
      t_class();
      t_chop();
      t_dis();
      t_start();
      close_out();
   end
endmodule
